// ==== hdl/port_validation_failsafe.sv ====
// Per-port identity check, fail-safe output choice and digital bit
// mapping of the status/control word of a point-to-point I/O master.
// Assumes identity and process data come from logic on sys_clk, while
// the digital pin levels arrive asynchronously from the port pins.
// Operation
// RULE1 - With no validation the port starts exchange without any check.
// RULE2 - Compatible mode requires maker and product codes to match.
// RULE3 - Identical mode also requires the serial number to match.
// RULE4 - Software gives the maker code as high byte then low byte.
// RULE5 - Software gives the product code as three bytes, high first.
// RULE6 - The configured serial number holds at most 16 characters.
// RULE7 - Substitution acts only in COM mode on ports with output data.
// RULE8 - Set-low sends all zeros, the default; set-high sends all ones.
// RULE9 - Hold-last keeps sending the last valid controller value.
// RULE10 - Replacement sends the configured substitute value every cycle.
// RULE11 - Master-command marks data invalid and lets the device decide.
// RULE12 - Software gives the substitute value most significant unit first.
// RULE13 - The status/control word is 4 bytes each way, bits and status.
// RULE14 - Alternating mapping interleaves line and channel-B bits.
// RULE15 - Grouped mapping puts all line bits before all channel-B bits.
// RULE16 - A failed check blocks exchange and sets a readable flag.
`timescale 1ns/1ns
`include "pvf_defs.svh"
module port_validation_failsafe
    import pvf_pkg::*;
#(
    parameter int PD_W = `PVF_PD_W,
    parameter int SER_W = `PVF_SERIAL_W
)(
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // Port configuration.
    input  wire logic                    comMode,
    input  wire logic                    outputsUsed,
    input  wire pvf_pkg::valmode_t       valMode,
    input  wire logic [7:0]              cfgMakerHi,
    input  wire logic [7:0]              cfgMakerLo,
    input  wire logic [7:0]              cfgProductHi,
    input  wire logic [7:0]              cfgProductMid,
    input  wire logic [7:0]              cfgProductLo,
    input  wire logic [SER_W-1:0]        cfgSerial,
    input  wire pvf_pkg::failsafe_t      fsMode,
    input  wire logic [PD_W-1:0]         substValue,
    input  wire pvf_pkg::mapmode_t       mapMode,
    // Identity reported by the attached device.
    input  wire logic                    idValid,
    input  wire logic [15:0]             devMakerCode,
    input  wire logic [23:0]             devProductCode,
    input  wire logic [SER_W-1:0]        devSerial,
    input  wire logic                    linkDown,
    // Cyclic output data from the controller.
    input  wire logic                    ctrlDataGood,
    input  wire logic                    ctrlValid,
    output      logic                    ctrlReady,
    input  wire logic [PD_W-1:0]         ctrlData,
    // Output data toward the attached device.
    output      logic                    pdValid,
    input  wire logic                    pdReady,
    output      logic [PD_W-1:0]         pdData,
    output      logic                    pdDataOk,
    // Validation status.
    output      logic                    exchangeOn,
    output      logic                    diagFail,
    input  wire logic                    diagClr,
    // Status/control module and digital pins.
    input  wire logic [`PVF_PORTS-1:0]   sigPin,
    input  wire logic [`PVF_PORTS-1:0]   chbPin,
    input  wire logic [`PVF_STAT_W-1:0]  masterStat,
    output      logic [`PVF_SC_W-1:0]    scIn,
    input  wire logic [`PVF_SC_W-1:0]    scOut,
    output      logic [`PVF_PORTS-1:0]   sigOut,
    output      logic [`PVF_PORTS-1:0]   chbOut,
    output      logic [`PVF_STAT_W-1:0]  masterCtl
);
    import pvf_pkg::*;

    localparam int NP = `PVF_PORTS;

    pvf_state_t state_r;
    pvf_state_t state_nxt;

    pd_buf_if #(.W(PD_W + 1)) bufLink ();

    logic [PD_W:0] headWord;

    // Packs per-port line and channel-B bits into the digital field.
    function automatic logic [2*NP-1:0] packDig(
        input mapmode_t      mode,
        input logic [NP-1:0] sig,
        input logic [NP-1:0] chb
    );
        logic [2*NP-1:0] r;
        r = '0;
        for (int p = 0; p < NP; p++)
        begin
            if (mode == MAP_GROUP)
            begin
                r[p]      = sig[p];       // see RULE15
                r[NP + p] = chb[p];
            end
            else
            begin
                r[2*p]     = sig[p];      // see RULE14
                r[2*p + 1] = chb[p];
            end
        end
        return r;
    endfunction

    // Splits the digital field back into line and channel-B bits.
    function automatic logic [2*NP-1:0] unpackDig(
        input mapmode_t        mode,
        input logic [2*NP-1:0] v
    );
        logic [2*NP-1:0] r;
        r = '0;
        for (int p = 0; p < NP; p++)
        begin
            if (mode == MAP_GROUP)
            begin
                r[p]      = v[p];         // see RULE15
                r[NP + p] = v[NP + p];
            end
            else
            begin
                r[p]      = v[2*p];       // see RULE14
                r[NP + p] = v[2*p + 1];
            end
        end
        return r;
    endfunction

    always_comb
    begin
        logic            ctrlOk;
        logic            subst;
        logic [PD_W-1:0] fsWord;
        logic            fsGood;
        logic [2*NP-1:0] digOut;
        ctrlOk = 1'b0;
        subst  = 1'b0;
        fsWord = '0;
        fsGood = 1'b1;
        digOut = '0;
        state_nxt = state_r;

        // Identity check, restarted whenever the port leaves COM mode.
        case (state_r.vState)
            ST_WAIT:
            begin
                if (idValid)
                begin
                    state_nxt.makerOk = (devMakerCode ==
                        {cfgMakerHi, cfgMakerLo});            // see RULE4
                    state_nxt.productOk = (devProductCode == {cfgProductHi,
                        cfgProductMid, cfgProductLo});        // see RULE5
                    state_nxt.serialOk = (devSerial == cfgSerial); // see RULE6
                    state_nxt.vState = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                case (valMode)
                    VAL_COMPAT:
                        state_nxt.exchangeOn = state_r.makerOk
                            & state_r.productOk;              // see RULE2
                    VAL_IDENT:
                        state_nxt.exchangeOn = state_r.makerOk
                            & state_r.productOk
                            & state_r.serialOk;               // see RULE3
                    default:
                        state_nxt.exchangeOn = 1'b1;          // see RULE1
                endcase
                state_nxt.vState = state_nxt.exchangeOn ? ST_RUN : ST_FAIL;
            end
            ST_RUN:
            begin
                state_nxt.vState = ST_RUN;
            end
            ST_FAIL:
            begin
                state_nxt.exchangeOn = 1'b0;                  // see RULE16
            end
            default:
            begin
                state_nxt.vState = ST_WAIT;
            end
        endcase
        if (!comMode || linkDown)
        begin
            state_nxt.vState     = ST_WAIT;
            state_nxt.exchangeOn = 1'b0;
        end

        // A fresh failure wins over a clear in the same cycle.
        if (diagClr)
        begin
            state_nxt.diagFail = 1'b0;
        end
        // A restart during the check is not a failed identity.
        if (state_r.vState == ST_CHECK && state_nxt.vState == ST_FAIL)
        begin
            state_nxt.diagFail = 1'b1;                        // see RULE16
        end

        // Fail-safe word choice.
        ctrlOk = ctrlDataGood;
        subst  = state_r.exchangeOn & comMode & outputsUsed
               & ~ctrlOk;                                     // see RULE7
        case (fsMode)
            FS_HIGH:  fsWord = '1;                            // see RULE8
            FS_HOLD:  fsWord = state_r.holdVal;               // see RULE9
            FS_SUBST: fsWord = substValue; // see RULE10 RULE12
            FS_MCMD:
            begin
                fsWord = state_r.holdVal;
                fsGood = 1'b0;                                // see RULE11
            end
            default:  fsWord = '0;                            // see RULE8
        endcase
        // Only a word the controller actually handed over is remembered.
        if (ctrlOk && ctrlValid && bufLink.ready && state_r.exchangeOn)
        begin
            state_nxt.holdVal = ctrlData;                     // see RULE9
        end

        // Status/control word, both directions.
        state_nxt.pinMeta = {chbPin, sigPin};
        state_nxt.pinSync = state_r.pinMeta;
        state_nxt.scIn = {masterStat,
            packDig(mapMode, state_r.pinSync[NP-1:0],
                    state_r.pinSync[2*NP-1:NP])};             // see RULE13
        digOut = unpackDig(mapMode,
            scOut[`PVF_DIG_LSB +: `PVF_DIG_W]);
        state_nxt.sigOut    = digOut[NP-1:0];
        state_nxt.chbOut    = digOut[2*NP-1:NP];
        state_nxt.masterCtl = scOut[`PVF_STAT_LSB +: `PVF_STAT_W];

        // Buffer feed; nothing flows while the port is not exchanging.
        bufLink.valid = 1'b0;
        bufLink.data  = '0;
        if (state_r.exchangeOn && comMode && outputsUsed)
        begin
            if (subst)
            begin
                bufLink.valid = 1'b1;                         // see RULE10
                bufLink.data  = {fsGood, fsWord};
            end
            else
            begin
                bufLink.valid = ctrlValid;
                bufLink.data  = {1'b1, ctrlData};
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= '0;
            state_r.vState <= ST_WAIT;
            state_r.holdVal <= `PVF_HOLD_RST;
            state_r.scIn <= `PVF_SC_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    pd_two_buf #(.W(PD_W + 1)) outBuf (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .fill     (bufLink.sink),
        .outValid (pdValid),
        .outReady (pdReady),
        .outData  (headWord)
    );

    assign ctrlReady  = bufLink.ready & state_r.exchangeOn;
    assign pdData     = headWord[PD_W-1:0];
    assign pdDataOk   = headWord[PD_W];
    assign exchangeOn = state_r.exchangeOn;
    assign diagFail   = state_r.diagFail;
    assign scIn       = state_r.scIn;
    assign sigOut     = state_r.sigOut;
    assign chbOut     = state_r.chbOut;
    assign masterCtl  = state_r.masterCtl;

endmodule

// ==== hdl/pvf_defs.svh ====
// Constants of the port validation and fail-safe block.
// Assumes inclusion by the package and the top module; macros are then global.
`ifndef PVF_DEFS_SVH
`define PVF_DEFS_SVH

// Process data word toward the attached device, in bits.
`define PVF_PD_W        32
// Serial number length in characters and in bits.
`define PVF_SERIAL_CHARS 16
`define PVF_SERIAL_W    128
// Status/control module: 4 bytes each way.
`define PVF_SC_BYTES    4
`define PVF_SC_W        32
// Ports served by the status/control module and digital bit count.
`define PVF_PORTS       8
`define PVF_DIG_W       16
// Field positions inside the 32-bit status/control word.
`define PVF_DIG_LSB     0
`define PVF_STAT_LSB    16
`define PVF_STAT_W      16
// Reset values.
`define PVF_HOLD_RST    32'h0000_0000
`define PVF_DIG_RST     16'h0000
`define PVF_SC_RST      32'h0000_0000

`endif

// ==== hdl/pvf_pkg.sv ====
// Types shared by the port validation and fail-safe block.
// Assumes pvf_defs.svh is on the include path.
`include "pvf_defs.svh"
package pvf_pkg;

    typedef enum logic [1:0] {
        VAL_NONE   = 2'h0,
        VAL_COMPAT = 2'h1,
        VAL_IDENT  = 2'h2
    } valmode_t;

    typedef enum logic [2:0] {
        FS_LOW   = 3'h0,
        FS_HIGH  = 3'h1,
        FS_HOLD  = 3'h2,
        FS_SUBST = 3'h3,
        FS_MCMD  = 3'h4
    } failsafe_t;

    typedef enum logic {
        MAP_ALT   = 1'b0,
        MAP_GROUP = 1'b1
    } mapmode_t;

    // Gray codes along wait, check, run; fail sits beside run.
    typedef enum logic [1:0] {
        ST_WAIT  = 2'h0,
        ST_CHECK = 2'h1,
        ST_RUN   = 2'h3,
        ST_FAIL  = 2'h2
    } vstate_t;

    typedef struct packed {
        vstate_t                    vState;
        logic                       makerOk;
        logic                       productOk;
        logic                       serialOk;
        logic                       exchangeOn;
        logic                       diagFail;
        logic [`PVF_PD_W-1:0]       holdVal;
        logic [2*`PVF_PORTS-1:0]    pinMeta;
        logic [2*`PVF_PORTS-1:0]    pinSync;
        logic [`PVF_SC_W-1:0]       scIn;
        logic [`PVF_PORTS-1:0]      sigOut;
        logic [`PVF_PORTS-1:0]      chbOut;
        logic [`PVF_STAT_W-1:0]     masterCtl;
    } pvf_state_t;

endpackage

// ==== hdl/pd_buf_if.sv ====
// Valid/ready carrier between the fail-safe selector and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface pd_buf_if #(
    parameter int W = 33
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ==== hdl/pd_two_buf.sv ====
// Two-entry buffer; every output comes from a flip-flop.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pd_two_buf #(
    parameter int W = 33
)(
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Filling side.
    pd_buf_if.sink            fill,
    // Draining side.
    output      logic         outValid,
    input  wire logic         outReady,
    output      logic [W-1:0] outData
);

    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic [1:0]   count;
        logic         notEmpty;
        logic         notFull;
    } buf_state_t;

    buf_state_t state_r;
    buf_state_t state_nxt;

    always_comb
    begin
        logic       push;
        logic       pop;
        logic [1:0] left;
        push = 1'b0;
        pop  = 1'b0;
        left = 2'h0;
        state_nxt = state_r;
        push = fill.valid & state_r.notFull;
        pop  = state_r.notEmpty & outReady;
        left = state_r.count - {1'b0, pop};
        if (pop)
        begin
            state_nxt.head = state_r.tail;
        end
        if (push)
        begin
            if (left == 2'h0)
            begin
                state_nxt.head = fill.data;
            end
            else
            begin
                state_nxt.tail = fill.data;
            end
        end
        state_nxt.count    = left + {1'b0, push};
        state_nxt.notEmpty = (state_nxt.count != 2'h0);
        state_nxt.notFull  = (state_nxt.count != 2'h2);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= '0;
            state_r.notFull <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign fill.ready = state_r.notFull;
    assign outValid   = state_r.notEmpty;
    assign outData    = state_r.head;

endmodule

// ==== tb/pvf_asserts.sv ====
// Checker of the port validation and fail-safe block, bound to its top.
// Assumes it sees the top module's ports only, on one clock.
`timescale 1ns/1ns
module pvf_asserts
    import pvf_pkg::*;
#(
    parameter int PD_W  = 32,
    parameter int SER_W = 128
)(
    // Clock and reset.
    input wire logic              sys_clk,
    input wire logic              rst,
    // Configuration and identity.
    input wire logic              comMode,
    input wire pvf_pkg::valmode_t valMode,
    input wire pvf_pkg::mapmode_t mapMode,
    input wire logic [7:0]        cfgMakerHi,
    input wire logic [7:0]        cfgMakerLo,
    input wire logic [7:0]        cfgProductHi,
    input wire logic [7:0]        cfgProductMid,
    input wire logic [7:0]        cfgProductLo,
    input wire logic [SER_W-1:0]  cfgSerial,
    input wire logic              idValid,
    input wire logic [15:0]       devMakerCode,
    input wire logic [23:0]       devProductCode,
    input wire logic [SER_W-1:0]  devSerial,
    // Data path and status.
    input wire logic              ctrlReady,
    input wire logic              pdValid,
    input wire logic              pdReady,
    input wire logic [PD_W-1:0]   pdData,
    input wire logic              exchangeOn,
    input wire logic              diagFail,
    input wire logic              diagClr,
    // Status/control word.
    input wire logic [31:0]       scOut,
    input wire logic [7:0]        sigOut,
    input wire logic [7:0]        chbOut,
    input wire logic [15:0]       masterCtl
);
    logic [31:0] scOutQ;
    logic [7:0]  altSig;
    logic [7:0]  altChb;

    always_ff @(posedge sys_clk)
        scOutQ <= scOut;

    always_comb
        for (int p = 0; p < 8; p++)
        begin
            altSig[p] = scOutQ[2*p];
            altChb[p] = scOutQ[2*p+1];
        end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_PASS_AFTER_ID: assert property (
        $rose(exchangeOn) |-> $past(idValid, 2))
        else $error("exchange began without identity");
    AST_COMPAT_MATCH: assert property (
        $rose(exchangeOn) && $past(valMode, 2) inside {VAL_COMPAT, VAL_IDENT}
        |-> $past(devMakerCode, 2) == {cfgMakerHi, cfgMakerLo}
        && $past(devProductCode, 2)
        == {cfgProductHi, cfgProductMid, cfgProductLo})
        else $error("exchange began with wrong codes");
    AST_IDENT_SERIAL: assert property (
        $rose(exchangeOn) && $past(valMode, 2) == VAL_IDENT
        |-> $past(devSerial, 2) == cfgSerial)
        else $error("exchange began with wrong serial");
    AST_FAIL_AFTER_ID: assert property (
        $rose(diagFail) |-> $past(idValid, 2) && !exchangeOn)
        else $error("fail flag without identity");
    AST_DIAG_STICKY: assert property (
        diagFail && !diagClr |=> diagFail)
        else $error("fail flag dropped without clear");
    AST_COM_OFF: assert property (
        !comMode ##1 !comMode |=> !exchangeOn && !ctrlReady)
        else $error("exchange kept outside COM mode");
    AST_PD_HOLD: assert property (
        pdValid && !pdReady |=> pdValid && $stable(pdData))
        else $error("stalled word changed or vanished");
    AST_ALT_OUT: assert property (
        !$past(rst) && $past(mapMode) == MAP_ALT
        |-> sigOut == altSig && chbOut == altChb)
        else $error("alternating output bits wrong");
    AST_GRP_OUT: assert property (
        !$past(rst) && $past(mapMode) == MAP_GROUP
        |-> {masterCtl, chbOut, sigOut} == scOutQ)
        else $error("grouped output bits wrong");
endmodule

bind port_validation_failsafe pvf_asserts #(.PD_W(PD_W), .SER_W(SER_W))
    pvf_asserts_inst (.sys_clk, .rst, .comMode, .valMode, .mapMode,
    .cfgMakerHi, .cfgMakerLo, .cfgProductHi, .cfgProductMid,
    .cfgProductLo, .cfgSerial, .idValid, .devMakerCode, .devProductCode,
    .devSerial, .ctrlReady, .pdValid, .pdReady, .pdData, .exchangeOn,
    .diagFail, .diagClr, .scOut, .sigOut, .chbOut, .masterCtl);

// ==== tb/pvf_dev_model.sv ====
// Attached device: reports its identity and takes output data.
// Assumes the bench steers it through report and stall.
`timescale 1ns/1ns
module pvf_dev_model (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Steering.
    input  wire logic         report,
    input  wire logic         stall,
    input  wire logic [15:0]  mk,
    input  wire logic [23:0]  pr,
    input  wire logic [127:0] sn,
    // Identity.
    output      logic         idValid,
    output      logic [15:0]  devMakerCode,
    output      logic [23:0]  devProductCode,
    output      logic [127:0] devSerial,
    // Output data.
    input  wire logic         pdValid,
    output      logic         pdReady,
    input  wire logic [31:0]  pdData,
    input  wire logic         pdDataOk,
    // Received words, newest lowest.
    output      logic [31:0]  rxCount,
    output      logic [127:0] rxHist,
    output      logic         rxOk
);
    // Fields read as garbage outside the valid cycle.
    assign devMakerCode   = idValid ? mk : ~mk;
    assign devProductCode = idValid ? pr : ~pr;
    assign devSerial      = idValid ? sn : ~sn;
    assign pdReady        = ~stall & ~rst;

    always_ff @(posedge sys_clk)
        if (rst)
        begin
            idValid <= 1'b0;
            rxCount <= 32'h0;
            rxHist  <= 128'h0;
            rxOk    <= 1'b0;
        end
        else
        begin
            idValid <= report;
            if (pdValid && pdReady)
            begin
                rxCount <= rxCount + 32'h1;
                rxHist  <= {rxHist[95:0], pdData};
                rxOk    <= pdDataOk;
            end
        end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the port validation and fail-safe block.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ns
module testbench;
    import pvf_pkg::*;
    localparam logic [31:0] W1 = 32'h13579BDF;
    logic        sys_clk = 1'b0, rst = 1'b1, comMode = 1'b1, report = 1'b0;
    logic        outputsUsed = 1'b1, linkDown = 1'b0, diagClr = 1'b0;
    logic        ctrlDataGood = 1'b1, ctrlValid = 1'b0, stall = 1'b0;
    logic        idValid, ctrlReady, pdValid, pdReady, pdDataOk, rxOk;
    logic        exchangeOn, diagFail;
    valmode_t    valMode = VAL_NONE;
    failsafe_t   fsMode = FS_LOW;
    mapmode_t    mapMode = MAP_ALT;
    logic [7:0]  sigPin = 8'hA1, chbPin = 8'h3C, sigOut, chbOut;
    logic [15:0] cfgMk = 16'h1234, mk = 16'h0, devMakerCode;
    logic [15:0] masterStat = 16'h5AC3, masterCtl;
    logic [23:0] cfgPr = 24'hABCDEF, pr = 24'h0, devProductCode;
    logic [31:0] substValue = 32'hA5C30F96, ctrlData = 32'h0;
    logic [31:0] pdData, scIn, scOut = 32'h0, rxCount;
    logic [127:0] cfgSn = "SN00000000000042", sn = 128'h0;
    logic [127:0] devSerial, rxHist;
    int          checked = 0, bad_count = 0;

    always #20 sys_clk = ~sys_clk;

    port_validation_failsafe port_validation_failsafe_inst (
        .sys_clk, .rst, .comMode, .outputsUsed, .valMode,
        .cfgMakerHi(cfgMk[15:8]), .cfgMakerLo(cfgMk[7:0]),
        .cfgProductHi(cfgPr[23:16]), .cfgProductMid(cfgPr[15:8]),
        .cfgProductLo(cfgPr[7:0]), .cfgSerial(cfgSn), .fsMode,
        .substValue, .mapMode, .idValid, .devMakerCode, .devProductCode,
        .devSerial, .linkDown, .ctrlDataGood, .ctrlValid, .ctrlReady,
        .ctrlData, .pdValid, .pdReady, .pdData, .pdDataOk, .exchangeOn,
        .diagFail, .diagClr, .sigPin, .chbPin, .masterStat, .scIn,
        .scOut, .sigOut, .chbOut, .masterCtl);

    pvf_dev_model pvf_dev_model_inst (
        .sys_clk, .rst, .report, .stall, .mk, .pr, .sn, .idValid,
        .devMakerCode, .devProductCode, .devSerial, .pdValid, .pdReady,
        .pdData, .pdDataOk, .rxCount, .rxHist, .rxOk);

    task automatic report_and_stop;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic tmo(input int i, input int lim);
        if (i >= lim)
        begin
            bad_count++;
            report_and_stop;
        end
    endtask

    task automatic waitRx(input logic [31:0] n);
        int i;
        for (i = 0; i < 50 && rxCount < n; i++)
            @(negedge sys_clk);
        tmo(i, 50);
    endtask

    task automatic send(input logic [31:0] w);
        int i;
        ctrlValid <= 1'b1;
        ctrlData  <= w;
        for (i = 0; i < 50; i++)
        begin
            @(posedge sys_clk);
            if (ctrlReady === 1'b1)
                break;
        end
        tmo(i, 50);
    endtask

    task automatic validate(input valmode_t vm, input logic [15:0] m,
        input logic [23:0] p, input logic [127:0] s, input logic good);
        int i;
        @(posedge sys_clk);
        linkDown <= 1'b1;
        valMode  <= vm;
        mk       <= m;
        pr       <= p;
        sn       <= s;
        @(posedge sys_clk);
        linkDown <= 1'b0;
        diagClr  <= 1'b1;
        @(posedge sys_clk);
        diagClr <= 1'b0;
        report  <= 1'b1;
        @(posedge sys_clk);
        report <= 1'b0;
        for (i = 0; i < 8 && !(exchangeOn | diagFail); i++)
            @(negedge sys_clk);
        tmo(i, 8);
        chk({exchangeOn, diagFail}, {good, !good});
    endtask

    task automatic failsafe_modes;
        logic [31:0] expv [5];
        int          k;
        expv = '{32'h0, 32'hFFFFFFFF, W1, substValue, W1};
        @(posedge sys_clk);
        send(W1);
        ctrlValid <= 1'b0;
        waitRx(rxCount + 32'h1);
        chk({rxOk, rxHist[31:0]}, {1'b1, W1});
        @(posedge sys_clk);
        ctrlDataGood <= 1'b0;
        for (k = 0; k < 5; k++)
        begin
            @(posedge sys_clk);
            fsMode <= failsafe_t'(k);
            waitRx(rxCount + 32'h5);
            chk({rxOk, rxHist[31:0]}, {k != 4, expv[k]});
        end
    endtask

    task automatic buffer_stall;
        logic [31:0] c;
        @(posedge sys_clk);
        ctrlDataGood <= 1'b1;
        repeat (6) @(posedge sys_clk);
        stall <= 1'b1;
        @(posedge sys_clk);
        c = rxCount;
        send(32'h2468ACE0);
        send(32'h0F1E2D3C);
        ctrlData <= 32'h55AA33CC;
        repeat (4) @(posedge sys_clk);
        chk(ctrlReady, 1'b0);
        stall <= 1'b0;
        send(32'h55AA33CC);
        ctrlValid <= 1'b0;
        waitRx(c + 32'h3);
        chk(rxHist[95:0], 96'h2468ACE0_0F1E2D3C_55AA33CC);
    endtask

    task automatic no_outputs;
        logic [31:0] c;
        @(posedge sys_clk);
        ctrlDataGood <= 1'b0;
        outputsUsed  <= 1'b0;
        repeat (6) @(posedge sys_clk);
        c = rxCount;
        repeat (10) @(posedge sys_clk);
        chk(rxCount, c);
        outputsUsed <= 1'b1;
        comMode     <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({exchangeOn, rxCount}, {1'b0, c});
        comMode <= 1'b1;
    endtask

    task automatic bit_map;
        logic [15:0] e;
        logic [15:0] d;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge sys_clk);
            mapMode <= mapmode_t'(k);
            sigPin  <= 8'hA1 ^ {8{k[0]}};
            scOut   <= 32'h5A3C96E1 ^ k;
            repeat (4) @(posedge sys_clk);
            for (int p = 0; p < 8; p++)
            begin
                e[2*p +: 2] = {chbPin[p], sigPin[p]};
                d[p]        = scOut[2*p];
                d[8 + p]    = scOut[2*p + 1];
            end
            if (k == 1)
            begin
                e = {chbPin, sigPin};
                d = scOut[15:0];
            end
            chk(scIn, {masterStat, e});
            chk({masterCtl, chbOut, sigOut},
                {scOut[31:16], d});
        end
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk({exchangeOn, diagFail, pdValid, ctrlReady}, 4'h0);
        validate(VAL_NONE, 16'h0, 24'h0, 128'h0, 1'b1);
        validate(VAL_COMPAT, cfgMk, cfgPr, 128'h0, 1'b1);
        validate(valmode_t'(2'h3), 16'h0, 24'h0, 128'h0, 1'b1);
        validate(VAL_COMPAT, 16'h1235, cfgPr, cfgSn, 1'b0);
        validate(VAL_COMPAT, 16'h3412, cfgPr, cfgSn, 1'b0);
        validate(VAL_COMPAT, cfgMk, 24'hAACDEF, cfgSn, 1'b0);
        validate(VAL_COMPAT, cfgMk, 24'hEFCDAB, cfgSn, 1'b0);
        validate(VAL_IDENT, cfgMk, cfgPr, 128'h1, 1'b0);
        validate(VAL_IDENT, cfgMk, cfgPr, cfgSn, 1'b1);
        failsafe_modes;
        buffer_stall;
        no_outputs;
        bit_map;
        report_and_stop;
    end
endmodule
